// File: verilog/dpts_pkg.sv
package dpts_pkg;

    // ============================================================
    // Timing
    // ============================================================
    localparam int CLK_NS     = 10;
    localparam int T_SETUP_NS = 10;
    localparam int T_WP_NS    = 40;
    localparam int T_ACC_NS   = 55;
    localparam int T_GAP_NS   = 20;

    // Least times, rounded up to whole cycles
    localparam logic [3:0] SETUP_CYC = 4'((T_SETUP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] WP_CYC    = 4'((T_WP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] ACC_CYC   = 4'((T_ACC_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] GAP_CYC   = 4'((T_GAP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] CNT_ONE   = 4'h1;

    // ============================================================
    // Token space
    // ============================================================
    localparam int         NUM_FLAGS = 8;
    localparam logic [2:0] LAST_IDX  = 3'h7;
    localparam logic [2:0] IDX_ONE   = 3'h1;
    localparam logic [2:0] IDX_ZERO  = 3'h0;
    localparam logic [7:0] DATA_ZERO = 8'h00;

    // ============================================================
    // Types
    // ============================================================
    typedef enum logic [1:0] {
        OP_INIT    = 2'b00,
        OP_CLAIM   = 2'b01,
        OP_RELEASE = 2'b10,
        OP_READ    = 2'b11
    } dpts_op_type;

    typedef enum logic [1:0] {
        PEND_NONE  = 2'b00,
        PEND_READ  = 2'b01,
        PEND_WRITE = 2'b10
    } dpts_pend_type;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_WSETUP = 3'b001,
        ST_WPULSE = 3'b010,
        ST_WHOLD  = 3'b011,
        ST_RACC   = 3'b100,
        ST_GAP    = 3'b101
    } dpts_state_type;

    typedef struct packed {
        logic        valid;
        dpts_op_type op;
        logic [2:0]  idx;
        logic        persist;
    } dpts_cmd_type;

    typedef struct packed {
        logic       sel_n;
        logic       ce_n;
        logic       rw_n;
        logic       oe_n;
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       data_oe;
    } dpts_pins_type;

    typedef struct packed {
        logic done;
        logic granted;
        logic flag;
    } dpts_rsp_type;

    localparam dpts_pins_type PINS_IDLE = '{
        sel_n: 1'b1, ce_n: 1'b1, rw_n: 1'b1, oe_n: 1'b1,
        addr: 3'h0, wdata: 8'h00, data_oe: 1'b0
    };

    localparam dpts_rsp_type RSP_IDLE = '{done: 1'b0, granted: 1'b0, flag: 1'b1};

endpackage : dpts_pkg

// File: verilog/dpts_host.sv
// Functional notes
// (R1) Device holds eight independent token flags
// (R2) Zero claims a token, one releases it
// (R3) Select low, then ordinary SRAM access
// (R4) Only three low address bits pick flag
// (R5) Device samples only data bit zero
// (R6) Zero on free flag: ours zero, theirs one
// (R7) Owned flag changes only from owning side
// (R8) Owner writing one frees flag for both
// (R9) Other side's zero waits in request latch
// (R10) Pending request takes over on owner release
// (R11) Read spreads flag over all data bits
// (R12) Read value latched while select and enable
// (R13) Deassert select or enable between polls
// (R14) Write zero first, then read back
// (R15) Failed claim: keep reading or withdraw
// (R16) Simultaneous claims grant exactly one side
// (R17) Earlier request wins the token
// (R18) Same-instant requests resolved arbitrarily
// (R19) Software writes one to every flag at start
// (R20) Array enable held high during flag access
`timescale 1ns/1ps

module dpts_host (
    // Clock and reset
    input  wire logic                    ref_clk,
    input  wire logic                    rst_n,
    // User command side
    input  wire dpts_pkg::dpts_cmd_type  cmd,
    input  wire logic                    cancel,
    output logic                         ready,
    output dpts_pkg::dpts_rsp_type       rsp,
    // Device port pins
    output dpts_pkg::dpts_pins_type      pins,
    input  wire logic [7:0]              data_i
);
    import dpts_pkg::*;

    // ============================================================
    // State
    // ============================================================
    dpts_state_type state_r,   state_nxt;
    dpts_op_type    op_r,      op_nxt;
    dpts_pend_type  pend_r,    pend_nxt;
    dpts_pins_type  pins_r,    pins_nxt;
    dpts_rsp_type   rsp_r,     rsp_nxt;
    logic [3:0]     cnt_r,     cnt_nxt;
    logic [2:0]     idx_r,     idx_nxt;
    logic           persist_r, persist_nxt;
    logic           wval_r,    wval_nxt;
    logic           ready_r,   ready_nxt;

    // ============================================================
    // Pin helpers
    // ============================================================
    // (R3) SRAM-style token access
    function automatic dpts_pins_type write_pins(input logic [2:0] a, input logic v);
        dpts_pins_type p;
        p         = PINS_IDLE;
        p.sel_n   = 1'b0;
        // (R20) Array enable stays high
        p.ce_n    = 1'b1;
        p.addr    = a;
        // (R2) Value on every bit
        p.wdata   = {8{v}};
        p.data_oe = 1'b1;
        return p;
    endfunction : write_pins

    function automatic dpts_pins_type read_pins(input logic [2:0] a);
        dpts_pins_type p;
        p       = PINS_IDLE;
        p.sel_n = 1'b0;
        p.oe_n  = 1'b0;
        p.addr  = a;
        return p;
    endfunction : read_pins

    // ============================================================
    // Sequencer
    // ============================================================
    always_comb begin
        state_nxt   = state_r;
        op_nxt      = op_r;
        pend_nxt    = pend_r;
        pins_nxt    = pins_r;
        rsp_nxt     = rsp_r;
        cnt_nxt     = cnt_r;
        idx_nxt     = idx_r;
        persist_nxt = persist_r;
        wval_nxt    = wval_r;
        ready_nxt   = ready_r;
        rsp_nxt.done = 1'b0;
        if (cnt_r > CNT_ONE) begin
            cnt_nxt = cnt_r - CNT_ONE;
        end
        case (state_r)
            ST_IDLE: begin
                if (cmd.valid && ready_r) begin
                    ready_nxt       = 1'b0;
                    op_nxt          = cmd.op;
                    persist_nxt     = cmd.persist;
                    rsp_nxt.granted = 1'b0;
                    // (R19) Init walks all flags
                    idx_nxt = (cmd.op == OP_INIT) ? IDX_ZERO : cmd.idx;
                    if (cmd.op == OP_READ) begin
                        pins_nxt  = read_pins(cmd.idx);
                        cnt_nxt   = ACC_CYC;
                        state_nxt = ST_RACC;
                    end else begin
                        // (R14) Claim starts with a write
                        wval_nxt  = (cmd.op != OP_CLAIM);
                        pins_nxt  = write_pins((cmd.op == OP_INIT) ? IDX_ZERO : cmd.idx,
                                               cmd.op != OP_CLAIM);
                        cnt_nxt   = SETUP_CYC;
                        state_nxt = ST_WSETUP;
                    end
                end
            end
            ST_WSETUP: begin
                if (cnt_r == CNT_ONE) begin
                    pins_nxt.rw_n = 1'b0;
                    cnt_nxt       = WP_CYC;
                    state_nxt     = ST_WPULSE;
                end
            end
            ST_WPULSE: begin
                if (cnt_r == CNT_ONE) begin
                    pins_nxt.rw_n = 1'b1;
                    cnt_nxt       = SETUP_CYC;
                    state_nxt     = ST_WHOLD;
                end
            end
            ST_WHOLD: begin
                if (cnt_r == CNT_ONE) begin
                    pins_nxt  = PINS_IDLE;
                    cnt_nxt   = GAP_CYC;
                    state_nxt = ST_GAP;
                    if (op_r == OP_CLAIM && !wval_r) begin
                        // (R14) Read back to confirm
                        pend_nxt = PEND_READ;
                    end else if (op_r == OP_INIT && idx_r != LAST_IDX) begin
                        // (R19) Next flag of the init walk
                        idx_nxt  = idx_r + IDX_ONE;
                        pend_nxt = PEND_WRITE;
                    end else begin
                        pend_nxt = PEND_NONE;
                    end
                end
            end
            ST_RACC: begin
                if (cnt_r == CNT_ONE) begin
                    // (R13) Drop select and enable after each read
                    pins_nxt     = PINS_IDLE;
                    cnt_nxt      = GAP_CYC;
                    state_nxt    = ST_GAP;
                    pend_nxt     = PEND_NONE;
                    // (R11) All bits equal, bit zero taken
                    rsp_nxt.flag = data_i[0];
                    if (op_r == OP_CLAIM) begin
                        if (!data_i[0]) begin
                            // (R6) Zero here means ours
                            rsp_nxt.granted = 1'b1;
                        end else if (persist_r && !cancel) begin
                            // (R15) Keep polling, request stays latched
                            pend_nxt = PEND_READ;
                        end else begin
                            // (R15) Withdraw so nothing hangs
                            wval_nxt = 1'b1;
                            pend_nxt = PEND_WRITE;
                        end
                    end
                end
            end
            ST_GAP: begin
                if (cnt_r == CNT_ONE) begin
                    case (pend_r)
                        PEND_READ: begin
                            pins_nxt  = read_pins(idx_r);
                            cnt_nxt   = ACC_CYC;
                            state_nxt = ST_RACC;
                        end
                        PEND_WRITE: begin
                            pins_nxt  = write_pins(idx_r, wval_r);
                            cnt_nxt   = SETUP_CYC;
                            state_nxt = ST_WSETUP;
                        end
                        default: begin
                            rsp_nxt.done = 1'b1;
                            ready_nxt    = 1'b1;
                            state_nxt    = ST_IDLE;
                        end
                    endcase
                end
            end
            default: begin
                pins_nxt  = PINS_IDLE;
                ready_nxt = 1'b1;
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_r   <= ST_IDLE;
            op_r      <= OP_READ;
            pend_r    <= PEND_NONE;
            pins_r    <= PINS_IDLE;
            rsp_r     <= RSP_IDLE;
            cnt_r     <= CNT_ONE;
            idx_r     <= IDX_ZERO;
            persist_r <= 1'b0;
            wval_r    <= 1'b1;
            ready_r   <= 1'b1;
        end else begin
            state_r   <= state_nxt;
            op_r      <= op_nxt;
            pend_r    <= pend_nxt;
            pins_r    <= pins_nxt;
            rsp_r     <= rsp_nxt;
            cnt_r     <= cnt_nxt;
            idx_r     <= idx_nxt;
            persist_r <= persist_nxt;
            wval_r    <= wval_nxt;
            ready_r   <= ready_nxt;
        end
    end

    assign ready = ready_r;
    assign rsp   = rsp_r;
    assign pins  = pins_r;

endmodule : dpts_host

// File: verif/dpts_host_monitor.sv
`timescale 1ns/1ps
module dpts_host_monitor (
    // Clock and reset
    input wire logic                    ref_clk,
    input wire logic                    rst_n,
    // User side
    input wire dpts_pkg::dpts_cmd_type  cmd,
    input wire logic                    cancel,
    input wire logic                    ready,
    input wire dpts_pkg::dpts_rsp_type  rsp,
    // Device side
    input wire dpts_pkg::dpts_pins_type pins,
    input wire logic [7:0]              data_i
);
    import dpts_pkg::*;
    // ========
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    property p_ce; pins.ce_n; endproperty
    a_ce: assert property (p_ce) else $error("array enable low");
    property p_wr; !pins.rw_n |-> !pins.sel_n && pins.data_oe && pins.oe_n; endproperty
    a_wr: assert property (p_wr) else $error("bad write");
    property p_rd; !pins.oe_n |-> !pins.sel_n && pins.rw_n && !pins.data_oe; endproperty
    a_rd: assert property (p_rd) else $error("bad read");
    property p_wd; pins.data_oe |-> pins.wdata inside {8'h00, 8'hff}; endproperty
    a_wd: assert property (p_wd) else $error("mixed data");
    property p_rl; ready && cmd.valid && cmd.op == OP_READ |-> ##1 !ready ##8 rsp.done; endproperty
    a_rl: assert property (p_rl) else $error("read late");
    property p_rel;
        ready && cmd.valid && cmd.op == OP_RELEASE |->
            ##2 (!pins.rw_n && pins.wdata[0])[*4] ##1 pins.rw_n ##3 rsp.done;
    endproperty
    a_rel: assert property (p_rel) else $error("release shape");
    property p_cl;
        ready && cmd.valid && cmd.op == OP_CLAIM |=> !pins.sel_n && pins.wdata == DATA_ZERO;
    endproperty
    a_cl: assert property (p_cl) else $error("claim not write");
    property p_gap; $rose(pins.oe_n) |-> (pins.sel_n && pins.oe_n)[*2]; endproperty
    a_gap: assert property (p_gap) else $error("no poll gap");
    property p_fl; $rose(pins.oe_n) |-> rsp.flag == $past(data_i[0]); endproperty
    a_fl: assert property (p_fl) else $error("flag lost");
endmodule : dpts_host_monitor

bind dpts_host dpts_host_monitor i_mon (.ref_clk(ref_clk), .rst_n(rst_n), .cmd(cmd),
    .cancel(cancel), .ready(ready), .rsp(rsp), .pins(pins), .data_i(data_i));

// File: verif/dpts_dev_model.sv
`timescale 1ns/1ps
module dpts_dev_model (
    input wire logic                    ref_clk,
    input wire dpts_pkg::dpts_pins_type pins,
    // Far port
    input wire logic                    r_we,
    input wire logic [2:0]              r_idx,
    input wire logic                    r_val,
    output logic [7:0]                  data_i,
    output logic [7:0]                  r_flag
);
    import dpts_pkg::*;
    // ========
    // Eight flags, no power-up reset
    // tangled start
    logic [7:0] req_l = 8'h00, req_r = 8'h00, own_l = 8'h0f, own_r = 8'hf0;
    logic       prw = 1'b1, prd = 1'b1, lat = 1'b1;
    always @(posedge ref_clk) begin
        if (!pins.sel_n && pins.rw_n && !prw) req_l[pins.addr] = pins.wdata[0];
        if (r_we) req_r[r_idx] = r_val;
        for (int i = 0; i < NUM_FLAGS; i++) begin
            if (own_l[i] && req_l[i]) own_l[i] = 1'b0;
            if (own_r[i] && req_r[i]) own_r[i] = 1'b0;
            if (!own_l[i] && !own_r[i] && !req_l[i]) own_l[i] = 1'b1;
            else if (!own_l[i] && !own_r[i] && !req_r[i]) own_r[i] = 1'b1;
        end
        if (!pins.sel_n && !pins.oe_n && prd) lat <= ~own_l[pins.addr];
        prd <= pins.sel_n | pins.oe_n;
        prw <= pins.rw_n;
    end
    assign data_i = prd ? {8{~lat}} : {8{lat}};
    assign r_flag = ~own_r;
endmodule : dpts_dev_model

// File: verif/test_dual_port_token_semaphores.sv
`timescale 1ns/1ps
module test_dual_port_token_semaphores;
    import dpts_pkg::*;
    logic          ref_clk = 1'b0;
    logic          rst_n   = 1'b0;
    dpts_cmd_type  cmd     = '0;
    logic          cancel  = 1'b0;
    logic          ready;
    dpts_rsp_type  rsp;
    dpts_pins_type pins;
    logic [7:0]    data_i, r_flag;
    logic          r_we    = 1'b0;
    logic [2:0]    r_idx   = 3'h0;
    logic          r_val   = 1'b1;
    logic [2:0]    k;
    int            n_fail  = 0;
    int            checks  = 0;
    int            seed    = 87058;

    always #5 ref_clk = ~ref_clk;

    dpts_host i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .cmd(cmd), .cancel(cancel),
        .ready(ready), .rsp(rsp), .pins(pins), .data_i(data_i));
    dpts_dev_model i_dev (.ref_clk(ref_clk), .pins(pins), .r_we(r_we), .r_idx(r_idx),
        .r_val(r_val), .data_i(data_i), .r_flag(r_flag));

    // ========
    // Tasks
    task automatic finish_test;
        $display("n_fail=%0d checks=%0d", n_fail, checks);
        if (n_fail == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : finish_test

    task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk

    function automatic logic exp_flag(input logic owned);
        return ~owned;
    endfunction : exp_flag

    task automatic run(input dpts_op_type op, input logic [2:0] idx, input logic per);
        int n;
        n = 0;
        @(posedge ref_clk) #1;
        cmd = '{valid: 1'b1, op: op, idx: idx, persist: per};
        @(posedge ref_clk) #1;
        cmd.valid = 1'b0;
        while (rsp.done !== 1'b1) begin
            n++;
            if (n > 500) begin
                n_fail++;
                finish_test();
            end
            @(posedge ref_clk) #1;
        end
    endtask : run

    // Far port writes one flag
    task automatic rwr(input logic [2:0] idx, input logic v);
        @(posedge ref_clk) #1;
        r_we = 1'b1;
        r_idx = idx;
        r_val = v;
        @(posedge ref_clk) #1;
        r_we = 1'b0;
    endtask : rwr

    // ========
    // Scenarios
    initial begin
        repeat (8) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        chk(18'(pins), 18'(PINS_IDLE));
        for (int i = 0; i < 8; i++) rwr(3'(i), 1'b1);
        run(OP_INIT, IDX_ZERO, 1'b0);
        chk(18'(r_flag), 18'h00ff);
        // Far side can only take every flag if the init walk freed ours
        for (int i = 0; i < NUM_FLAGS; i++) rwr(3'(i), 1'b0);
        chk(18'(r_flag), 18'h0000);
        for (int i = 0; i < NUM_FLAGS; i++) rwr(3'(i), 1'b1);
        repeat (16) begin
            k = 3'($random(seed));
            run(OP_CLAIM, k, 1'b0);
            chk(18'(rsp.granted), 18'h1);
            chk(18'(r_flag[k]), 18'(exp_flag(1'b0)));
            run(OP_READ, k, 1'b0);
            chk(18'(rsp.flag), 18'(exp_flag(1'b1)));
            run(OP_RELEASE, k, 1'b0);
            run(OP_READ, k, 1'b0);
            chk(18'(rsp.flag), 18'(exp_flag(1'b0)));
        end
        rwr(3'h5, 1'b0);
        run(OP_CLAIM, 3'h5, 1'b0);
        chk(18'(rsp.granted), 18'h0);
        rwr(3'h5, 1'b1);
        run(OP_READ, 3'h5, 1'b0);
        chk(18'(rsp.flag), 18'h1);
        run(OP_CLAIM, 3'h3, 1'b0);
        rwr(3'h3, 1'b0);
        chk(18'(r_flag[3]), 18'h1);
        run(OP_RELEASE, 3'h3, 1'b0);
        chk(18'(r_flag[3]), 18'h0);
        rwr(3'h3, 1'b1);
        rwr(3'h6, 1'b0);
        fork
            run(OP_CLAIM, 3'h6, 1'b1);
            begin
                repeat (60) @(posedge ref_clk);
                rwr(3'h6, 1'b1);
            end
        join
        chk(18'(rsp.granted), 18'h1);
        run(OP_RELEASE, 3'h6, 1'b0);
        rwr(3'h7, 1'b0);
        cancel = 1'b1;
        run(OP_CLAIM, 3'h7, 1'b1);
        cancel = 1'b0;
        chk(18'(rsp.granted), 18'h0);
        rwr(3'h7, 1'b1);
        run(OP_READ, 3'h7, 1'b0);
        chk(18'(rsp.flag), 18'h1);
        finish_test();
    end
endmodule : test_dual_port_token_semaphores
